// >>> shared/capr_pkg.sv
package capr_pkg;
  // =====================================================
  // message framing
  localparam logic [23:0] TAG_VALUE = 24'h9F8032;
  localparam logic [7:0] POS_TAG0 = 8'h00;
  localparam logic [7:0] POS_TAG1 = 8'h01;
  localparam logic [7:0] POS_TAG2 = 8'h02;
  localparam logic [7:0] POS_LEN = 8'h03;
  localparam logic [7:0] POS_INDEX = 8'h04;
  localparam logic [7:0] POS_SEQ = 8'h05;
  localparam logic [7:0] POS_LTSID = 8'h06;
  localparam logic [7:0] POS_PROG_HI = 8'h07;
  localparam logic [7:0] POS_PROG_LO = 8'h08;
  localparam logic [7:0] POS_SRC_HI = 8'h09;
  localparam logic [7:0] POS_SRC_LO = 8'h0A;
  localparam logic [7:0] POS_CMD = 8'h0B;
  localparam logic [7:0] POS_PIL_HI = 8'h0C;
  localparam logic [7:0] POS_PIL_LO = 8'h0D;
  localparam int HDR_LEN = 14;
  localparam logic [8:0] LEN_OFFSET = 9'h003;
  localparam logic [2:0] ES_SUB_LEN_HI = 3'h3;
  localparam logic [2:0] ES_SUB_LEN_LO = 3'h4;
  localparam int ES_HDR_LEN = 5;
  localparam logic [7:0] CA_DESC_TAG = 8'h09;
  localparam logic [7:0] CA_DESC_BODY = 8'h04;
  localparam logic [11:0] DESC_LEN = 12'h006;
  localparam logic [11:0] ES_BODY_LEN = 12'h007;
  // =====================================================
  // command codes
  localparam logic [7:0] CMD_OK_DESCR = 8'h01;
  localparam logic [7:0] CMD_OK_DIALOG = 8'h02;
  localparam logic [7:0] CMD_QUERY = 8'h03;
  localparam logic [7:0] CMD_NOT_SEL = 8'h04;
  // =====================================================
  // capacity and sizes
  localparam int CAP_SLOTS = 4;
  localparam int SLOT_W = 2;
  localparam logic [7:0] CAP_SLOTS_B = 8'h04;
  localparam int ES_MAX = 2;
  localparam int ES_W = 1;
  localparam logic [2:0] ES_MAX_C = 3'h2;
  localparam int MSG_MAX = 44;
  localparam logic [7:0] SEQ_LAST = 8'hFE;
  localparam logic [7:0] SEQ_RESET = 8'h00;
  // =====================================================
  // answer kinds and host status codes
  localparam logic ANS_ANSWER = 1'b0;
  localparam logic ANS_UPDATE = 1'b1;
  localparam logic [1:0] STAT_SENT = 2'h0;
  localparam logic [1:0] STAT_SKIPPED = 2'h1;
  localparam logic [1:0] STAT_REFUSED = 2'h2;

  function automatic logic capr_cmd_reserved(input logic [7:0] c);
    return (c < CMD_OK_DESCR) || (c > CMD_NOT_SEL);
  endfunction

  // wraps modulo 255, so 0xFF is never used
  function automatic logic [7:0] capr_next_seq(input logic [7:0] s);
    return (s >= SEQ_LAST) ? SEQ_RESET : 8'(s + 8'h01);
  endfunction
endpackage

// >>> shared/capr_link_if.sv
interface capr_link_if;
  logic req_valid;
  logic [7:0] req_data;
  logic req_last;
  logic req_ready;
  logic ans_valid;
  logic ans_kind;
  logic [7:0] ans_index;
  logic [7:0] ans_seq;
  logic ans_ok;

  modport card (
    input req_valid, req_data, req_last,
    output req_ready, ans_valid, ans_kind, ans_index, ans_seq, ans_ok
  );
  modport host (
    output req_valid, req_data, req_last,
    input req_ready, ans_valid, ans_kind, ans_index, ans_seq, ans_ok
  );
endinterface

// >>> src/capr_card_end.sv
module capr_card_end
  import capr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  capr_link_if.card link,
  input wire logic i_entitled,
  input wire logic i_upd_req,
  input wire logic [SLOT_W-1:0] i_upd_slot,
  input wire logic i_upd_ok,
  input wire logic [SLOT_W-1:0] i_rd_slot,
  output logic [CAP_SLOTS-1:0] o_descramble,
  output logic [CAP_SLOTS-1:0] o_dialog,
  output logic o_drop,
  output logic o_rd_valid,
  output logic [7:0] o_rd_seq,
  output logic [7:0] o_rd_ltsid,
  output logic [15:0] o_rd_prog,
  output logic [15:0] o_rd_src,
  output logic [7:0] o_rd_cmd,
  output logic [2:0] o_rd_es_n,
  output logic [ES_MAX-1:0] o_rd_own,
  output logic [ES_MAX-1:0] o_rd_gov
);
  typedef enum logic [2:0] {
    P_HDR = 3'b000,
    P_PDESC = 3'b001,
    P_ES_HDR = 3'b010,
    P_ES_BODY = 3'b011,
    P_DROP = 3'b100
  } capr_phase_t;

  typedef struct packed {
    capr_phase_t phase;
    logic [7:0] pos;
    logic [7:0] len;
    logic [7:0] idx;
    logic [7:0] seq;
    logic [7:0] ltsid;
    logic [15:0] prog;
    logic [15:0] src;
    logic [7:0] cmd;
    logic [11:0] pil;
    logic [11:0] cnt;
    logic [2:0] sub;
    logic [2:0] es_n;
    logic [ES_MAX-1:0] own;
    logic [CAP_SLOTS-1:0] t_valid;
    logic [CAP_SLOTS-1:0][7:0] t_seq;
    logic [CAP_SLOTS-1:0][7:0] t_ltsid;
    logic [CAP_SLOTS-1:0][15:0] t_prog;
    logic [CAP_SLOTS-1:0][15:0] t_src;
    logic [CAP_SLOTS-1:0][7:0] t_cmd;
    logic [CAP_SLOTS-1:0][2:0] t_es_n;
    logic [CAP_SLOTS-1:0][ES_MAX-1:0] t_own;
    logic [CAP_SLOTS-1:0] t_pdesc;
    logic [CAP_SLOTS-1:0] descr;
    logic [CAP_SLOTS-1:0] dialog;
    logic ans_valid;
    logic ans_kind;
    logic [7:0] ans_index;
    logic [7:0] ans_seq;
    logic ans_ok;
    logic upd_pend;
    logic [SLOT_W-1:0] upd_slot;
    logic upd_ok;
    logic drop;
    logic rd_valid;
    logic [7:0] rd_seq;
    logic [7:0] rd_ltsid;
    logic [15:0] rd_prog;
    logic [15:0] rd_src;
    logic [7:0] rd_cmd;
    logic [2:0] rd_es_n;
    logic [ES_MAX-1:0] rd_own;
    logic [ES_MAX-1:0] rd_gov;
  } capr_card_t;

  capr_card_t q;
  capr_card_t d;
  logic [7:0] b;
  logic [SLOT_W-1:0] s;
  logic complete;

  function automatic logic [2:0] sat_inc(input logic [2:0] v);
    return (v == 3'h7) ? v : 3'(v + 3'h1);
  endfunction

  // =====================================================
  // parser, slot table and answers
  assign b = link.req_data;
  assign s = q.idx[SLOT_W-1:0];

  always_comb
  begin
    d = q;
    d.ans_valid = 1'b0;
    d.drop = 1'b0;
    complete = 1'b0;
    if (link.req_valid && link.req_ready)
    begin
      d.pos = (q.pos == 8'hFF) ? q.pos : 8'(q.pos + 8'h01);
      case (q.phase)
        P_HDR:
        begin
          case (q.pos)
            POS_TAG0: if (b != TAG_VALUE[23:16]) d.phase = P_DROP;
            POS_TAG1: if (b != TAG_VALUE[15:8]) d.phase = P_DROP;
            POS_TAG2: if (b != TAG_VALUE[7:0]) d.phase = P_DROP;
            // long length form is not supported: such messages are dropped
            POS_LEN:
            begin
              d.len = b;
              if (b[7]) d.phase = P_DROP;
            end
            POS_INDEX:
            begin
              d.idx = b;
              if (b >= CAP_SLOTS_B) d.phase = P_DROP;
            end
            POS_SEQ: d.seq = b;
            POS_LTSID: d.ltsid = b;
            POS_PROG_HI: d.prog[15:8] = b;
            POS_PROG_LO: d.prog[7:0] = b;
            POS_SRC_HI: d.src[15:8] = b;
            POS_SRC_LO: d.src[7:0] = b;
            POS_CMD:
            begin
              d.cmd = b;
              if (capr_cmd_reserved(b)) d.phase = P_DROP;
            end
            POS_PIL_HI: d.pil[11:8] = b[3:0];
            POS_PIL_LO:
            begin
              d.pil[7:0] = b;
              d.cnt = {q.pil[11:8], b};
              d.sub = 3'h0;
              d.es_n = 3'h0;
              d.own = '0;
              d.phase = ({q.pil[11:8], b} == 12'h000) ? P_ES_HDR : P_PDESC;
            end
            default: ;
          endcase
        end
        P_PDESC:
        begin
          d.cnt = 12'(q.cnt - 12'h001);
          if (q.cnt == 12'h001) d.phase = P_ES_HDR;
        end
        P_ES_HDR:
        begin
          d.sub = 3'(q.sub + 3'h1);
          if (q.sub == ES_SUB_LEN_HI) d.cnt[11:8] = b[3:0];
          if (q.sub == ES_SUB_LEN_LO)
          begin
            d.cnt[7:0] = b;
            d.sub = 3'h0;
            if ({q.cnt[11:8], b} != 12'h000)
            begin
              d.phase = P_ES_BODY;
              // a stream with its own descriptors is not governed by program level
              if (q.es_n < ES_MAX_C) d.own[q.es_n[ES_W-1:0]] = 1'b1;
            end
            else
              d.es_n = sat_inc(q.es_n);
          end
        end
        P_ES_BODY:
        begin
          d.cnt = 12'(q.cnt - 12'h001);
          if (q.cnt == 12'h001)
          begin
            d.phase = P_ES_HDR;
            d.es_n = sat_inc(q.es_n);
          end
        end
        P_DROP: ;
        default: d.phase = P_DROP;
      endcase
      if (link.req_last)
      begin
        // nothing reaches the table until the whole message has checked out
        complete = (d.phase == P_ES_HDR) && (d.sub == 3'h0) &&
                   ({1'b0, q.pos} == 9'({1'b0, q.len} + LEN_OFFSET));
        d.phase = P_HDR;
        d.pos = 8'h00;
        d.sub = 3'h0;
        d.drop = !complete;
        if (complete)
        begin
          // a new request replaces whatever the slot held before
          d.t_valid[s] = 1'b1;
          d.t_seq[s] = q.seq;
          d.t_ltsid[s] = q.ltsid;
          d.t_prog[s] = q.prog;
          d.t_src[s] = q.src;
          d.t_cmd[s] = q.cmd;
          d.t_es_n[s] = d.es_n;
          d.t_own[s] = d.own;
          d.t_pdesc[s] = (q.pil != 12'h000);
          case (q.cmd)
            CMD_OK_DESCR:
            begin
              // without entitlement the card opens a purchase dialog instead
              d.descr[s] = i_entitled;
              d.dialog[s] = !i_entitled;
            end
            CMD_OK_DIALOG:
            begin
              d.descr[s] = 1'b0;
              d.dialog[s] = 1'b1;
            end
            CMD_QUERY:
            begin
              d.descr[s] = 1'b0;
              d.dialog[s] = 1'b0;
              d.ans_valid = 1'b1;
              d.ans_kind = ANS_ANSWER;
              d.ans_index = q.idx;
              d.ans_seq = q.seq;
              d.ans_ok = i_entitled;
            end
            CMD_NOT_SEL:
            begin
              d.descr[s] = 1'b0;
              d.dialog[s] = 1'b0;
              d.t_valid[s] = 1'b0;
            end
            default: ;
          endcase
        end
      end
    end
    // a pending update waits while an answer takes the channel
    if (q.upd_pend && !d.ans_valid)
    begin
      d.ans_valid = 1'b1;
      d.ans_kind = ANS_UPDATE;
      d.ans_index = 8'(q.upd_slot);
      d.ans_seq = q.t_seq[q.upd_slot];
      d.ans_ok = q.upd_ok;
      d.upd_pend = 1'b0;
    end
    if (i_upd_req && q.t_valid[i_upd_slot])
    begin
      d.upd_pend = 1'b1;
      d.upd_slot = i_upd_slot;
      d.upd_ok = i_upd_ok;
    end
    d.rd_valid = q.t_valid[i_rd_slot];
    d.rd_seq = q.t_seq[i_rd_slot];
    d.rd_ltsid = q.t_ltsid[i_rd_slot];
    d.rd_prog = q.t_prog[i_rd_slot];
    d.rd_src = q.t_src[i_rd_slot];
    d.rd_cmd = q.t_cmd[i_rd_slot];
    d.rd_es_n = q.t_es_n[i_rd_slot];
    d.rd_own = q.t_own[i_rd_slot];
    d.rd_gov = q.t_pdesc[i_rd_slot] ? ~q.t_own[i_rd_slot] : '0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      q <= '0;
    else
      q <= d;
  end

  // =====================================================
  // outputs
  // one byte is parsed per cycle, so the card never stalls the host
  assign link.req_ready = 1'b1;
  assign link.ans_valid = q.ans_valid;
  assign link.ans_kind = q.ans_kind;
  assign link.ans_index = q.ans_index;
  assign link.ans_seq = q.ans_seq;
  assign link.ans_ok = q.ans_ok;
  assign o_descramble = q.descr;
  assign o_dialog = q.dialog;
  assign o_drop = q.drop;
  assign o_rd_valid = q.rd_valid;
  assign o_rd_seq = q.rd_seq;
  assign o_rd_ltsid = q.rd_ltsid;
  assign o_rd_prog = q.rd_prog;
  assign o_rd_src = q.rd_src;
  assign o_rd_cmd = q.rd_cmd;
  assign o_rd_es_n = q.rd_es_n;
  assign o_rd_own = q.rd_own;
  assign o_rd_gov = q.rd_gov;
endmodule

// >>> src/capr_host_end.sv
// Behaviour
// - slot index below card capacity
// - 8-bit sequence value echoed back
// - sequence advances by one modulo 255
// - separate sequence counter per slot
// - host always fills stream identifier
// - reserved command codes never issued
// - ok-descramble: no answer, may descramble
// - ok-dialog: no descrambling until ok-descramble
// - query: answer, no descramble or dialog
// - not-selected: stop descrambling, close dialog
// - resend on program, version, indicator change
// - one request per selected program
// - only access descriptors copied
// - program descriptors cover streams without own
// - descriptors keep original level
// - slot index carried, card mirrors table
// - slot assignment overwritten on replacement
// - card reallocates slot on new request
// - card echoes sequence in answers, updates
module capr_host_end
  import capr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  capr_link_if.host link,
  input wire logic i_req,
  input wire logic i_force,
  input wire logic [7:0] i_slot,
  input wire logic [7:0] i_ltsid,
  input wire logic [15:0] i_prog,
  input wire logic [15:0] i_src,
  input wire logic [7:0] i_cmd,
  input wire logic [4:0] i_version,
  input wire logic i_cni,
  input wire logic i_dialog_ok,
  input wire logic i_pdesc_en,
  input wire logic [15:0] i_pdesc_sys,
  input wire logic [12:0] i_pdesc_ecm,
  input wire logic [1:0] i_es_cnt,
  input wire logic [ES_MAX-1:0][7:0] i_es_type,
  input wire logic [ES_MAX-1:0][12:0] i_es_pid,
  input wire logic [ES_MAX-1:0] i_es_desc_en,
  input wire logic [ES_MAX-1:0][15:0] i_es_sys,
  input wire logic [ES_MAX-1:0][12:0] i_es_ecm,
  output logic o_req_ready,
  output logic o_stat_valid,
  output logic [1:0] o_stat_code,
  output logic [7:0] o_stat_seq,
  output logic o_ans_valid,
  output logic o_ans_kind,
  output logic [7:0] o_ans_index,
  output logic [7:0] o_ans_seq,
  output logic o_ans_ok,
  output logic o_ans_fresh
);
  typedef enum logic [0:0] {
    H_IDLE = 1'b0,
    H_SEND = 1'b1
  } capr_hstate_t;

  typedef struct packed {
    logic [MSG_MAX-1:0][7:0] b;
    logic [7:0] n;
  } capr_msg_t;

  typedef struct packed {
    capr_hstate_t st;
    logic [MSG_MAX-1:0][7:0] buffer;
    logic [7:0] rem;
    logic [CAP_SLOTS-1:0][7:0] seq_cnt;
    logic [CAP_SLOTS-1:0][7:0] last_seq;
    logic [CAP_SLOTS-1:0] sent_valid;
    logic [CAP_SLOTS-1:0][15:0] sent_prog;
    logic [CAP_SLOTS-1:0][4:0] sent_ver;
    logic [CAP_SLOTS-1:0] sent_cni;
    logic [CAP_SLOTS-1:0][7:0] sent_cmd;
    logic stat_valid;
    logic [1:0] stat_code;
    logic [7:0] stat_seq;
    logic ans_valid;
    logic ans_kind;
    logic [7:0] ans_index;
    logic [7:0] ans_seq;
    logic ans_ok;
    logic ans_fresh;
  } capr_host_t;

  capr_host_t q;
  capr_host_t d;
  capr_msg_t msg;
  logic [SLOT_W-1:0] s;
  logic [SLOT_W-1:0] as;
  logic refuse;
  logic same;

  // six descriptor bytes, highest index sent first
  function automatic logic [5:0][7:0] ca_desc(input logic [15:0] sys, input logic [12:0] entitlement_control_stream);
    return {CA_DESC_TAG, CA_DESC_BODY, sys[15:8], sys[7:0], {3'b111, entitlement_control_stream[12:8]}, entitlement_control_stream[7:0]};
  endfunction

  // =====================================================
  // message builder
  // only access descriptors are ever generated, each at the level it was given
  function automatic capr_msg_t build(input logic [7:0] seq);
    capr_msg_t m;
    logic [5:0][7:0] dsc;
    logic [11:0] pil;
    logic [11:0] esl;
    int p;
    m = '0;
    pil = i_pdesc_en ? DESC_LEN : 12'h000;
    m.b[0] = TAG_VALUE[23:16];
    m.b[1] = TAG_VALUE[15:8];
    m.b[2] = TAG_VALUE[7:0];
    m.b[4] = i_slot;
    m.b[5] = seq;
    m.b[6] = i_ltsid;
    m.b[7] = i_prog[15:8];
    m.b[8] = i_prog[7:0];
    m.b[9] = i_src[15:8];
    m.b[10] = i_src[7:0];
    m.b[11] = i_cmd;
    m.b[12] = {4'hF, pil[11:8]};
    m.b[13] = pil[7:0];
    p = HDR_LEN;
    if (i_pdesc_en)
    begin
      dsc = ca_desc(i_pdesc_sys, i_pdesc_ecm);
      for (int k = 0; k < 6; k++)
        m.b[p + k] = dsc[5 - k];
      p = p + 6;
    end
    for (int i = 0; i < ES_MAX; i++)
    begin
      if (i < int'(i_es_cnt))
      begin
        esl = i_es_desc_en[i] ? ES_BODY_LEN : 12'h000;
        m.b[p] = i_es_type[i];
        m.b[p + 1] = {3'b111, i_es_pid[i][12:8]};
        m.b[p + 2] = i_es_pid[i][7:0];
        m.b[p + 3] = {4'hF, esl[11:8]};
        m.b[p + 4] = esl[7:0];
        p = p + ES_HDR_LEN;
        if (i_es_desc_en[i])
        begin
          dsc = ca_desc(i_es_sys[i], i_es_ecm[i]);
          m.b[p] = i_cmd;
          for (int k = 0; k < 6; k++)
            m.b[p + 1 + k] = dsc[5 - k];
          p = p + 7;
        end
      end
    end
    m.n = 8'(p);
    m.b[3] = 8'(p - 4);
    return m;
  endfunction

  // =====================================================
  // request acceptance and sending
  assign s = i_slot[SLOT_W-1:0];
  assign as = link.ans_index[SLOT_W-1:0];
  always_comb msg = build(q.seq_cnt[s]);
  // a dialog request is refused unless a dialog session can be opened
  assign refuse = (i_slot >= CAP_SLOTS_B) || capr_cmd_reserved(i_cmd) ||
                  ((i_cmd == CMD_OK_DIALOG) && !i_dialog_ok);
  assign same = q.sent_valid[s] && (q.sent_prog[s] == i_prog) && (q.sent_ver[s] == i_version) &&
                (q.sent_cni[s] == i_cni) && (q.sent_cmd[s] == i_cmd);

  always_comb
  begin
    d = q;
    d.stat_valid = 1'b0;
    d.ans_valid = 1'b0;
    case (q.st)
      H_IDLE:
      begin
        if (i_req)
        begin
          d.stat_valid = 1'b1;
          d.stat_seq = 8'h00;
          if (refuse)
            d.stat_code = STAT_REFUSED;
          else if (same && !i_force)
            d.stat_code = STAT_SKIPPED;
          else
          begin
            // any change of program, version or indicator forces a new message
            d.stat_code = STAT_SENT;
            d.stat_seq = q.seq_cnt[s];
            d.buffer = msg.b;
            d.rem = msg.n;
            d.st = H_SEND;
            d.last_seq[s] = q.seq_cnt[s];
            d.seq_cnt[s] = capr_next_seq(q.seq_cnt[s]);
            d.sent_valid[s] = 1'b1;
            d.sent_prog[s] = i_prog;
            d.sent_ver[s] = i_version;
            d.sent_cni[s] = i_cni;
            d.sent_cmd[s] = i_cmd;
          end
        end
      end
      H_SEND:
      begin
        if (link.req_ready)
        begin
          // shifting keeps the byte on the link straight from a flop
          d.buffer = q.buffer >> 8;
          d.rem = 8'(q.rem - 8'h01);
          if (q.rem == 8'h01) d.st = H_IDLE;
        end
      end
      default: d.st = H_IDLE;
    endcase
    if (link.ans_valid)
    begin
      d.ans_valid = 1'b1;
      d.ans_kind = link.ans_kind;
      d.ans_index = link.ans_index;
      d.ans_seq = link.ans_seq;
      d.ans_ok = link.ans_ok;
      // an answer not carrying the latest value of its slot is obsolete
      d.ans_fresh = (link.ans_index < CAP_SLOTS_B) && q.sent_valid[as] &&
                    (link.ans_seq == q.last_seq[as]);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      q <= '0;
    else
      q <= d;
  end

  // =====================================================
  // outputs
  assign link.req_valid = (q.st == H_SEND);
  assign link.req_data = q.buffer[0];
  assign link.req_last = (q.st == H_SEND) && (q.rem == 8'h01);
  assign o_req_ready = (q.st == H_IDLE);
  assign o_stat_valid = q.stat_valid;
  assign o_stat_code = q.stat_code;
  assign o_stat_seq = q.stat_seq;
  assign o_ans_valid = q.ans_valid;
  assign o_ans_kind = q.ans_kind;
  assign o_ans_index = q.ans_index;
  assign o_ans_seq = q.ans_seq;
  assign o_ans_ok = q.ans_ok;
  assign o_ans_fresh = q.ans_fresh;
endmodule

// >>> tb/capr_link_monitor.sv
module capr_link_monitor
  import capr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic req_valid,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  input wire logic req_ready,
  input wire logic ans_valid,
  input wire logic ans_kind,
  input wire logic [7:0] ans_index,
  input wire logic [7:0] ans_seq,
  input wire logic ans_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // byte position and captured fields
  logic [7:0] pos_q, len_q, idx_q, seq_q, cmd_q;
  logic [7:0] nxt_q [CAP_SLOTS];
  wire take = req_valid && req_ready;
  wire done = take && req_last;
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      pos_q <= 8'h00;
      nxt_q <= '{default: 8'h00};
    end
    else if (take)
    begin
      pos_q <= done ? 8'h00 : 8'(pos_q + 8'h01);
      if (pos_q == POS_LEN)
        len_q <= req_data;
      if (pos_q == POS_INDEX)
        idx_q <= req_data;
      if (pos_q == POS_CMD)
        cmd_q <= req_data;
      if (pos_q == POS_SEQ)
        seq_q <= req_data;
      // expected next value per slot, wrapping modulo 255
      if (pos_q == POS_SEQ)
        nxt_q[idx_q[SLOT_W-1:0]] <= (req_data == 8'hFE) ? 8'h00 : 8'(req_data + 8'h01);
    end
  end
  default clocking mon_cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========
  // link checks
  a_tag_bytes: assert property (take && pos_q < 8'h03 |-> req_data == TAG_VALUE[8*(2-pos_q) +: 8])
    else $error("tag byte wrong");
  a_length_frame: assert property (done |-> pos_q == 8'(len_q + 8'h03))
    else $error("last byte off length");
  a_index_range: assert property (take && pos_q == POS_INDEX |-> req_data < CAP_SLOTS_B)
    else $error("slot index too big");
  a_seq_no_ff: assert property (take && pos_q == POS_SEQ |-> req_data != 8'hFF)
    else $error("sequence value FF");
  a_seq_per_slot: assert property (take && pos_q == POS_SEQ |-> req_data == nxt_q[idx_q[SLOT_W-1:0]])
    else $error("sequence not advanced per slot");
  a_cmd_legal: assert property (take && pos_q == POS_CMD |-> req_data inside {[8'h01:8'h04]})
    else $error("reserved command sent");
  a_query_answer: assert property (done && cmd_q == CMD_QUERY |=> ans_valid && !ans_kind
    && ans_seq == seq_q && ans_index == idx_q)
    else $error("query answer wrong");
  a_silent_cmds: assert property (done && cmd_q != CMD_QUERY |=> !(ans_valid && !ans_kind))
    else $error("answer without query");
  c_query: cover property (done && cmd_q == CMD_QUERY);
  c_update: cover property (ans_valid && ans_kind && ans_ok);
  c_wrap: cover property (take && pos_q == POS_SEQ && req_data == 8'hFE);
endmodule

// >>> tb/ca_program_map_request_handler_tb.sv
module ca_program_map_request_handler_tb
  import capr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_req, i_force, i_cni, i_dialog_ok, i_pdesc_en, i_entitled, i_upd_req, i_upd_ok;
  logic [7:0] i_slot, i_ltsid, i_cmd, o_stat_seq, o_ans_index, o_ans_seq, o_rd_seq, o_rd_ltsid, o_rd_cmd;
  logic [15:0] i_prog, i_src, i_pdesc_sys, o_rd_prog, o_rd_src;
  logic [12:0] i_pdesc_ecm;
  logic [4:0] i_version;
  logic [1:0] i_es_cnt, i_upd_slot, i_rd_slot, o_stat_code;
  logic [ES_MAX-1:0][7:0] i_es_type;
  logic [ES_MAX-1:0][12:0] i_es_pid, i_es_ecm;
  logic [ES_MAX-1:0][15:0] i_es_sys;
  logic [ES_MAX-1:0] i_es_desc_en, o_rd_own, o_rd_gov;
  logic [CAP_SLOTS-1:0] o_descramble, o_dialog;
  logic o_req_ready, o_stat_valid, o_ans_valid, o_ans_kind, o_ans_ok, o_ans_fresh, o_rd_valid, o_drop;
  logic [2:0] o_rd_es_n;
  logic [18:0] ans_q;
  logic [7:0] nxt [4] = '{default: 8'h00};
  logic [7:0] lst [4] = '{default: 8'h00};
  int fail_count = 0;
  int checks = 0;
  int ans_n = 0;
  always #5 i_mclk = ~i_mclk;
  capr_link_if link();
  capr_card_end capr_card_end_inst (.i_mclk, .i_sys_rst, .link, .i_entitled, .i_upd_req, .i_upd_slot,
    .i_upd_ok, .i_rd_slot, .o_descramble, .o_dialog, .o_drop, .o_rd_valid, .o_rd_seq, .o_rd_ltsid,
    .o_rd_prog, .o_rd_src, .o_rd_cmd, .o_rd_es_n, .o_rd_own, .o_rd_gov);
  capr_host_end capr_host_end_inst (.i_mclk, .i_sys_rst, .link, .i_req, .i_force, .i_slot, .i_ltsid,
    .i_prog, .i_src, .i_cmd, .i_version, .i_cni, .i_dialog_ok, .i_pdesc_en, .i_pdesc_sys, .i_pdesc_ecm,
    .i_es_cnt, .i_es_type, .i_es_pid, .i_es_desc_en, .i_es_sys, .i_es_ecm, .o_req_ready, .o_stat_valid,
    .o_stat_code, .o_stat_seq, .o_ans_valid, .o_ans_kind, .o_ans_index, .o_ans_seq, .o_ans_ok, .o_ans_fresh);
  capr_link_monitor capr_link_monitor_inst (.i_mclk, .i_sys_rst, .req_valid(link.req_valid),
    .req_data(link.req_data), .req_last(link.req_last), .req_ready(link.req_ready),
    .ans_valid(link.ans_valid), .ans_kind(link.ans_kind), .ans_index(link.ans_index),
    .ans_seq(link.ans_seq), .ans_ok(link.ans_ok));
  // ==========
  // answer capture, so checks need not hit the one-cycle pulse
  always @(posedge i_mclk)
  begin
    if (o_ans_valid === 1'b1)
    begin
      ans_n <= ans_n + 1;
      ans_q <= {o_ans_kind, o_ans_ok, o_ans_fresh, o_ans_index, o_ans_seq};
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask
  // ==========
  // one request: status checked, then wait for the message and the table
  task automatic send(input logic [7:0] s, input logic [7:0] c, input logic f, input logic [1:0] code);
    int n;
    logic [7:0] q;
    n = 0;
    q = (code == STAT_SENT) ? nxt[s[1:0]] : 8'h00;
    @(posedge i_mclk);
    i_req <= 1'b1;
    i_slot <= s;
    i_cmd <= c;
    i_force <= f;
    i_prog <= {s, c};
    i_ltsid <= s ^ 8'h5A;
    i_src <= {c, s};
    i_rd_slot <= s[1:0];
    @(posedge i_mclk);
    i_req <= 1'b0;
    #1;
    chk("status", {13'h0, 1'b1, code, q}, {13'h0, o_stat_valid, o_stat_code, o_stat_seq});
    if (code == STAT_SENT)
    begin
      lst[s[1:0]] = q;
      nxt[s[1:0]] = (q == 8'hFE) ? 8'h00 : 8'(q + 8'h01);
    end
    while (o_req_ready !== 1'b1 && n < 60)
    begin
      tick;
      n++;
    end
    chk("idle", 24'h2, {22'h0, o_req_ready, o_drop});
    repeat (3) tick;
  endtask
  task automatic t_cmds;
    int a;
    for (int c = 1; c <= 4; c++)
    begin
      a = ans_n;
      send(8'h00, 8'(c), 1'b0, STAT_SENT);
      chk("descramble", 24'(c == 1), {23'h0, o_descramble[0]});
      chk("dialog", 24'(c == 2), {23'h0, o_dialog[0]});
      chk("answers", 24'(a + (c == 3)), 24'(ans_n));
      chk("slot", {15'h0, 1'(c != 4), lst[0]}, {15'h0, o_rd_valid, o_rd_seq});
      if (c == 3)
        chk("answer", {5'h0, 3'b011, 8'h00, lst[0]}, {5'h0, ans_q});
    end
    $display("test commands done");
  endtask
  task automatic t_refuse;
    send(8'h04, CMD_QUERY, 1'b1, STAT_REFUSED);
    send(8'h00, 8'h00, 1'b1, STAT_REFUSED);
    send(8'h00, 8'h05, 1'b1, STAT_REFUSED);
    @(posedge i_mclk);
    i_dialog_ok <= 1'b0;
    send(8'h00, CMD_OK_DIALOG, 1'b1, STAT_REFUSED);
    @(posedge i_mclk) i_dialog_ok <= 1'b1;
    send(8'h00, CMD_NOT_SEL, 1'b0, STAT_SKIPPED);
    @(posedge i_mclk) i_cni <= 1'b1;
    send(8'h00, CMD_NOT_SEL, 1'b0, STAT_SENT);
    @(posedge i_mclk) i_version <= 5'h03;
    send(8'h00, CMD_NOT_SEL, 1'b0, STAT_SENT);
    $display("test refusals done");
  endtask
  task automatic t_wrap;
    for (int k = 0; k < 256; k++)
      send(8'h01, CMD_OK_DESCR, 1'b1, STAT_SENT);
    send(8'h00, CMD_OK_DESCR, 1'b1, STAT_SENT);
    $display("test wrap done");
  endtask
  task automatic t_desc;
    @(posedge i_mclk);
    i_pdesc_en <= 1'b1;
    i_es_cnt <= 2'h2;
    i_es_desc_en <= 2'b01;
    i_es_pid <= {13'h0051, 13'h0052};
    send(8'h02, CMD_OK_DESCR, 1'b1, STAT_SENT);
    chk("streams", {17'h0, 3'h2, 2'b01, 2'b10}, {17'h0, o_rd_es_n, o_rd_own, o_rd_gov});
    chk("program", 24'h010201, {o_rd_cmd, o_rd_prog});
    chk("fields", 24'h580102, {o_rd_ltsid, o_rd_src});
    @(posedge i_mclk);
    i_pdesc_en <= 1'b0;
    i_es_desc_en <= 2'b10;
    send(8'h02, CMD_OK_DESCR, 1'b1, STAT_SENT);
    chk("streams", {17'h0, 3'h2, 2'b10, 2'b00}, {17'h0, o_rd_es_n, o_rd_own, o_rd_gov});
    $display("test descriptors done");
  endtask
  task automatic t_update;
    int a;
    a = ans_n;
    @(posedge i_mclk);
    i_upd_req <= 1'b1;
    i_upd_slot <= 2'h2;
    i_upd_ok <= 1'b1;
    @(posedge i_mclk);
    i_upd_req <= 1'b0;
    repeat (3) tick;
    chk("updates", 24'(a + 1), 24'(ans_n));
    chk("update", {5'h0, 3'b111, 8'h02, lst[2]}, {5'h0, ans_q});
    $display("test update done");
  endtask
  initial
  begin
    {i_req, i_force, i_cni, i_pdesc_en, i_upd_req, i_upd_ok} = '0;
    {i_dialog_ok, i_entitled} = 2'b11;
    {i_slot, i_ltsid, i_cmd, i_prog, i_src, i_pdesc_sys, i_pdesc_ecm, i_version} = '0;
    {i_es_cnt, i_upd_slot, i_rd_slot, i_es_type, i_es_pid, i_es_ecm, i_es_sys, i_es_desc_en} = '0;
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_cmds;
    t_refuse;
    t_wrap;
    t_desc;
    t_update;
    test_done;
  end
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    test_done;
  end
endmodule
